// ==== rtl/sgan_pkg.sv ====
//
// Purpose: constants and types for the sgmii ability-word block
// Assumes: registers are 16 bits wide, one per aligned apb word
// Notes: printed offsets are word indexes; byte address is four times
//
// How it works
// - mac role sends fixed word 16'h4001, ignoring local advertisement
// - mac role takes speed and duplex from peer word on completion
// - bits 11:10 code speed: 00 10M, 01 100M, 10 1G, 11 reserved
// - bit 12 gives duplex: 1 full, 0 half
// - mac role stores peer bit 14 as received; no logic reads it
// - bit 15 gives line link: 1 up, 0 down
// - phy role takes speed and duplex from local word on completion
// - phy role local bit 14 is read-only acknowledge from the device
// - expansion bit 0 shows partner negotiation ability, resets to 0
// - expansion bit 1 sets when a new partner page arrives
// - reading expansion clears bit 1; reset value 0
// - expansion bits 15:2 always read as 0
// - role select 1 picks phy role, 0 mac role, resets to 0
//
package sgan_pkg;

  // ****************************************************************
  // register indexes (byte address = 4 * index)
  // ****************************************************************
  localparam logic [5:0] SGAN_IDX_LOCAL = 6'h04;
  localparam logic [5:0] SGAN_IDX_PEER = 6'h05;
  localparam logic [5:0] SGAN_IDX_EXPAN = 6'h06;
  localparam logic [5:0] SGAN_IDX_MODE = 6'h14;
  localparam logic [5:0] SGAN_IDX_RESULT = 6'h15;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SGAN_ACK_BIT = 14;
  localparam int SGAN_EXP_ABLE_BIT = 0;
  localparam int SGAN_EXP_PAGE_BIT = 1;
  localparam int SGAN_MODE_ROLE_BIT = 5;
  localparam int SGAN_RES_DONE_BIT = 0;
  localparam int SGAN_RES_SPD_LSB = 1;
  localparam int SGAN_RES_DPX_BIT = 3;
  localparam int SGAN_RES_LINK_BIT = 4;

  // ****************************************************************
  // reset values and fixed words
  // ****************************************************************
  localparam logic [15:0] SGAN_MAC_WORD = 16'h4001;
  localparam logic [15:0] SGAN_LOCAL_RST = 16'h0001;
  localparam logic [15:0] SGAN_PEER_RST = 16'h0000;
  localparam logic [1:0] SGAN_SPEED_RST = 2'h0;
  localparam logic SGAN_ROLE_RST = 1'b0;
  localparam int SGAN_MATCH_COUNT = 3;

  // ****************************************************************
  // speed codes and roles
  // ****************************************************************
  typedef enum logic [1:0] {
    SGAN_SPD_10M = 2'h0,
    SGAN_SPD_100M = 2'h1,
    SGAN_SPD_1G = 2'h2,
    SGAN_SPD_RSVD = 2'h3
  } sgan_speed_e;

  typedef enum logic {
    SGAN_ROLE_MAC = 1'b0,
    SGAN_ROLE_PHY = 1'b1
  } sgan_role_e;

  // ****************************************************************
  // ability word layout
  // ****************************************************************
  typedef struct packed {
    logic link;
    logic ack;
    logic rsvd13;
    logic duplex;
    logic [1:0] speed;
    logic [9:0] rsvd;
  } sgan_word_s;

  // resolved operating point
  typedef struct packed {
    logic link;
    logic duplex;
    logic [1:0] speed;
  } sgan_result_s;

endpackage

// ==== rtl/sgan_match.sv ====
//
// Purpose: acknowledge from consecutive matching received ability words
// Assumes: word_valid pulses once per received word, same clock
// Notes: the acknowledge bit itself is left out of the comparison
//
`timescale 1ns/1ps
module sgan_match
  import sgan_pkg::*;
#(
  parameter int COUNT = SGAN_MATCH_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic word_valid,
  input wire logic [15:0] word,
  output logic ack
);

  typedef struct packed {
    logic [15:0] last;
    logic [3:0] run;
    logic ack;
  } sgan_match_state_s;

  sgan_match_state_s st, next_st;
  logic same;

  // ****************************************************************
  // run length of identical words
  // ****************************************************************
  always_comb begin
    next_st = st;
    same = (word[15] == st.last[15]) && (word[13:0] == st.last[13:0]);
    if (restart) begin
      next_st.run = 4'h0;
      next_st.ack = 1'b0;
    end else if (word_valid) begin
      next_st.last = word;
      if (same && st.run != 4'h0) begin
        if (st.run < 4'(COUNT)) begin
          next_st.run = st.run + 4'h1;
        end
      end else begin
        next_st.run = 4'h1;
      end
      next_st.ack = (same && st.run != 4'h0 &&
                     st.run + 4'h1 >= 4'(COUNT)) ||
                    (same && st.ack);
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ack = st.ack;

endmodule // sgan_match

// ==== rtl/sgan_ability.sv ====
//
// Purpose: sgmii ability words, result resolution, expansion status
// Assumes: apb slave, pclk 40 MHz, link engine on the same clock
// Notes: no wait state on any apb access; pready from a flop
//
`timescale 1ns/1ps
module sgan_ability
  import sgan_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_page,
  input wire logic [15:0] rx_word,
  input wire logic an_complete,
  input wire logic an_restart,
  input wire logic partner_an_able,
  output logic [15:0] tx_ability,
  output logic [1:0] op_speed,
  output logic op_duplex,
  output logic op_link
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] local_adv;
    logic [15:0] peer_adv;
    logic page;
    logic able;
    logic role;
    sgan_result_s res;
    logic done;
    logic done_q;
    logic rdy;
    logic [31:0] rdata;
    logic err;
    logic [15:0] tx;
  } sgan_state_s;

  sgan_state_s st, next_st;

  logic ack_local;
  logic setup;
  logic access;
  logic hit;
  logic [5:0] idx;
  logic [15:0] rd_word;
  logic [15:0] local_view;
  logic [15:0] exp_view;
  logic [15:0] mode_view;
  logic [15:0] res_view;
  sgan_word_s chosen;

  // ****************************************************************
  // acknowledge for the phy role
  // ****************************************************************
  sgan_match #(
    .COUNT(SGAN_MATCH_COUNT)
  ) sgan_match_i (
    .pclk(pclk),
    .presetn(presetn),
    .restart(an_restart),
    .word_valid(rx_page),
    .word(rx_word),
    .ack(ack_local)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign setup = psel && !penable;
  assign access = psel && penable && st.rdy;
  assign idx = paddr[7:2];

  // register views as software sees them
  always_comb begin
    local_view = st.local_adv;
    local_view[SGAN_ACK_BIT] = ack_local;
    exp_view = 16'h0000;
    exp_view[SGAN_EXP_ABLE_BIT] = st.able;
    exp_view[SGAN_EXP_PAGE_BIT] = st.page;
    mode_view = 16'h0000;
    mode_view[SGAN_MODE_ROLE_BIT] = st.role;
    res_view = 16'h0000;
    res_view[SGAN_RES_DONE_BIT] = st.done;
    res_view[SGAN_RES_SPD_LSB +: 2] = st.res.speed;
    res_view[SGAN_RES_DPX_BIT] = st.res.duplex;
    res_view[SGAN_RES_LINK_BIT] = st.res.link;
  end

  // read mux, unmapped words flagged
  always_comb begin
    rd_word = 16'h0000;
    hit = 1'b1;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else begin
      case (idx)
        SGAN_IDX_LOCAL: begin
          rd_word = local_view;
        end
        SGAN_IDX_PEER: begin
          rd_word = st.peer_adv;
        end
        SGAN_IDX_EXPAN: begin
          rd_word = exp_view;
        end
        SGAN_IDX_MODE: begin
          rd_word = mode_view;
        end
        SGAN_IDX_RESULT: begin
          rd_word = res_view;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // word used for resolution in each role
  always_comb begin
    if (st.role == SGAN_ROLE_PHY) begin
      chosen = sgan_word_s'(st.local_adv);
    end else begin
      chosen = sgan_word_s'(st.peer_adv);
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;

    // apb handshake: no wait state, answer staged at setup
    next_st.rdy = setup && !st.rdy;
    if (setup) begin
      next_st.rdata = {16'h0000, rd_word};
      next_st.err = !hit;
    end else if (access) begin
      next_st.rdata = 32'h0000_0000;
      next_st.err = 1'b0;
    end

    // software writes, taken at the completing edge
    if (access && pwrite && hit) begin
      case (idx)
        SGAN_IDX_LOCAL: begin
          next_st.local_adv = pwdata[15:0];
        end
        SGAN_IDX_MODE: begin
          next_st.role = pwdata[SGAN_MODE_ROLE_BIT];
        end
        default: begin
          next_st.role = st.role;
        end
      endcase
    end

    // partner ability capture
    next_st.able = partner_an_able;
    if (rx_page) begin
      next_st.peer_adv = rx_word;
    end

    // page flag: only a read that returned 1 clears, set wins
    if (access && !pwrite && idx == SGAN_IDX_EXPAN &&
        st.rdata[SGAN_EXP_PAGE_BIT]) begin
      next_st.page = 1'b0;
    end
    if (rx_page) begin
      next_st.page = 1'b1;
    end

    // completion tracking and resolution on its rising edge
    next_st.done_q = an_complete;
    if (an_restart) begin
      next_st.done = 1'b0;
    end else if (an_complete && !st.done_q) begin
      next_st.done = 1'b1;
      next_st.res.duplex = chosen.duplex;
      next_st.res.link = chosen.link;
      if (chosen.speed != SGAN_SPD_RSVD) begin
        next_st.res.speed = chosen.speed;
      end else begin
        next_st.res.speed = st.res.speed;
      end
    end else if (!an_complete) begin
      next_st.done = 1'b0;
    end

    // transmitted ability word for each role
    if (st.role == SGAN_ROLE_MAC) begin
      next_st.tx = SGAN_MAC_WORD;
    end else begin
      next_st.tx = local_view;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.local_adv <= SGAN_LOCAL_RST;
      st.peer_adv <= SGAN_PEER_RST;
      st.role <= SGAN_ROLE_RST;
      st.res.speed <= SGAN_SPEED_RST;
      st.tx <= SGAN_MAC_WORD;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign prdata = st.rdata;
  assign pready = st.rdy;
  assign pslverr = st.err;
  assign tx_ability = st.tx;
  assign op_speed = st.res.speed;
  assign op_duplex = st.res.duplex;
  assign op_link = st.res.link;

endmodule // sgan_ability

// ==== bench/sgan_ability_monitor.sv ====
// Purpose: port checks for the sgmii ability block
// Assumes: apb and link inputs share pclk
// Notes: role, local and peer words are shadowed from the ports
`timescale 1ns/1ps
module sgan_ability_monitor
  import sgan_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_page,
  input wire logic [15:0] rx_word,
  input wire logic an_complete,
  input wire logic an_restart,
  input wire logic [15:0] tx_ability,
  input wire logic [1:0] op_speed,
  input wire logic op_duplex,
  input wire logic op_link
);
  // ****************************************************************
  // shadow registers
  // ****************************************************************
  logic role_q;
  logic [15:0] local_q;
  logic [15:0] peer_q;
  logic [15:0] src;
  logic [1:0] src_spd;
  logic src_dpx;
  logic src_lnk;
  logic wr;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign src = role_q ? local_q : peer_q;
  assign src_spd = src[11:10];
  assign src_dpx = src[12];
  assign src_lnk = src[15];
  // follow completed writes and received pages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_q <= SGAN_ROLE_RST;
      local_q <= SGAN_LOCAL_RST;
      peer_q <= SGAN_PEER_RST;
    end else begin
      if (wr && paddr[7:2] == SGAN_IDX_MODE) role_q <= pwdata[5];
      if (wr && paddr[7:2] == SGAN_IDX_LOCAL) local_q <= pwdata[15:0];
      if (rx_page) peer_q <= rx_word;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_one: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  a_bad_addr: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not flagged");
  a_mac_word: assert property (
    !$past(role_q) && !role_q |-> tx_ability == SGAN_MAC_WORD)
    else $error("mac role word not fixed");
  a_phy_word: assert property (
    $past(role_q) && role_q && $stable(local_q)
    |-> tx_ability[13:0] == local_q[13:0])
    else $error("phy role word differs from local");
  a_res_speed: assert property (
    $rose(an_complete) && !an_restart && src_spd != 2'h3
    |=> op_speed == $past(src_spd))
    else $error("speed not resolved");
  a_res_duplex: assert property (
    $rose(an_complete) && !an_restart |=> op_duplex == $past(src_dpx))
    else $error("duplex not resolved");
  a_res_link: assert property (
    $rose(an_complete) && !an_restart |=> op_link == $past(src_lnk))
    else $error("link not resolved");
  a_keep_speed: assert property (
    $rose(an_complete) && !an_restart && src_spd == 2'h3
    |=> $stable(op_speed))
    else $error("reserved speed adopted");
  a_exp_zero: assert property (
    pready && !pwrite && paddr[7:2] == SGAN_IDX_EXPAN |-> prdata[31:2] == 0)
    else $error("expansion upper bits set");
endmodule // sgan_ability_monitor
bind sgan_ability sgan_ability_monitor #(.ADDR_W(ADDR_W)) mon_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_page(rx_page),
  .rx_word(rx_word), .an_complete(an_complete), .an_restart(an_restart),
  .tx_ability(tx_ability),
  .op_speed(op_speed), .op_duplex(op_duplex), .op_link(op_link));

// ==== bench/sgan_peer_model.sv ====
// Purpose: link partner sending ability words
// Assumes: words arrive already aligned to pclk
// Notes: released word line shows the inverse of the last word
`timescale 1ns/1ps
module sgan_peer_model (
  input wire logic pclk,
  output logic page,
  output logic [15:0] word,
  output logic able
);
  // ****************************************************************
  // idle line
  // ****************************************************************
  initial begin
    page = 1'b0;
    word = 16'h0000;
    able = 1'b0;
  end
  // sends a word n times back to back
  task automatic send(input logic [15:0] w, input int n);
    able <= 1'b1;
    repeat (n) begin
      @(posedge pclk);
      page <= 1'b1;
      word <= w;
    end
    @(posedge pclk);
    page <= 1'b0;
    word <= ~w;
  endtask
endmodule // sgan_peer_model

// ==== bench/test_sgan_ability.sv ====
// Purpose: register and resolution tests for the ability block
// Assumes: apb slave with no wait states
// Notes: words built from speed, duplex and link fields
`timescale 1ns/1ps
module test_sgan_ability;
  logic pclk, presetn, psel, penable, pwrite, an_complete, an_restart;
  logic pready, pslverr, op_duplex, op_link, rx_page, able, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] rx_word, tx_ability, w;
  logic [1:0] op_speed;
  int fails, num_checks;
  sgan_ability sgan_ability_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_page(rx_page), .rx_word(rx_word), .an_complete(an_complete),
    .an_restart(an_restart), .partner_an_able(able),
    .tx_ability(tx_ability), .op_speed(op_speed), .op_duplex(op_duplex),
    .op_link(op_link));
  sgan_peer_model sgan_peer_model_i (.pclk(pclk), .page(rx_page),
    .word(rx_word), .able(able));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic wr,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic complete();
    @(posedge pclk);
    an_complete <= 1'b1;
    repeat (2) @(posedge pclk);
    an_complete <= 1'b0;
  endtask
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    end_of_test();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, an_complete, an_restart, presetn} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h10, 32'h0001);
    rd(8'h14, 32'h0000);
    rd(8'h18, 32'h0000);
    rd(8'h50, 32'h0000);
    apb(8'h10, 1'b1, 32'h9C01);
    chk(32'(tx_ability), 32'h4001);
    sgan_peer_model_i.send(16'hD401, 3);
    rd(8'h18, 32'h0003);
    rd(8'h18, 32'h0001);
    rd(8'h14, 32'hD401);
    for (int i = 0; i < 4; i++) begin
      w = {~i[0], 2'b00, i[0], i[1:0], 10'h001};
      sgan_peer_model_i.send(w, 1);
      complete();
      chk(32'(op_speed), (i == 3) ? 32'h2 : 32'(i));
      chk(32'(op_duplex), 32'(i[0]));
      chk(32'(op_link), 32'(!i[0]));
    end
    apb(8'h0C, 1'b0, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(8'h11, 1'b1, 32'h0);
    chk(32'(rerr), 32'h1);
    @(posedge pclk);
    an_restart <= 1'b1;
    @(posedge pclk);
    an_restart <= 1'b0;
    apb(8'h50, 1'b1, 32'h20);
    rd(8'h50, 32'h0020);
    apb(8'h10, 1'b1, 32'h1801);
    repeat (2) @(posedge pclk);
    chk(32'(tx_ability), 32'h1801);
    sgan_peer_model_i.send(16'hD401, 3);
    repeat (2) @(posedge pclk);
    chk(32'(tx_ability), 32'h5801);
    rd(8'h10, 32'h5801);
    complete();
    chk(32'({op_link, op_duplex, op_speed}), 32'h6);
    rd(8'h14, 32'hD401);
    apb(8'h18, 1'b1, 32'hFFFF);
    rd(8'h18, 32'h0003);
    rd(8'h18, 32'h0001);
    end_of_test();
  end
endmodule // test_sgan_ability
